// ===== shared/rtchp_pkg.sv
/*
  Constants, field positions and pin bundles for the calendar clock host port.
  Assumes a single 100 MHz clock domain; all pin groups arrive unsynchronised.
*/
package rtchp_pkg;

  localparam int          CLK_MHZ        = 100;
  // power-loss lockout window, least figure in microseconds
  localparam int          LOCK_MIN_US    = 30;
  localparam int          LOCK_MAX_US    = 63;
  localparam int          LOCK_MIN_CYC   = LOCK_MIN_US * CLK_MHZ;
  localparam int          LOCK_MAX_CYC   = LOCK_MAX_US * CLK_MHZ;

  localparam int          SEL_W          = 5;
  localparam int          DATA_W         = 8;
  localparam int          PAGE_BYTES     = 31;

  // locations inside a page
  localparam logic [4:0]  ADDR_MAIN      = 5'h00;
  localparam logic [4:0]  ADDR_CTL_A     = 5'h01;
  localparam logic [4:0]  ADDR_CTL_B     = 5'h02;
  localparam logic [4:0]  ADDR_RT_MODE   = 5'h03;

  // main status register fields
  localparam int          MS_IRQ         = 0;
  localparam int          MS_SUPPLY_LOSS_N       = 1;
  localparam int          MS_PERIODIC    = 2;
  localparam int          MS_ALARM       = 3;
  localparam int          MS_BLOCK       = 6;
  localparam int          MS_PAGE        = 7;
  localparam logic [7:0]  MS_W1C_MASK    = 8'h0E;

  // interrupt control fields (control block 1)
  localparam int          IC0_PERIODIC   = 0;
  localparam int          IC0_ALARM      = 1;
  localparam int          IC1_SUPPLY_LOSS_N      = 7;
  // real-time mode fields (control block 1)
  localparam int          RTM_XSEL_LO    = 0;
  localparam int          RTM_MFO_OSC    = 3;
  localparam logic [2:0]  XSEL_FIRST     = 3'h1;
  localparam logic [2:0]  XSEL_LAST      = 3'h4;
  localparam logic [7:0]  CTL_RESET      = 8'h00;

  typedef struct packed {
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic [SEL_W-1:0]  register_select_lines;
    logic [DATA_W-1:0] data;
  } rtchp_pins_t;

  typedef struct packed {
    logic supply_loss_n;
    logic battery_standby;
    logic crystal_input;
  } rtchp_power_t;

endpackage : rtchp_pkg

// ===== src/rtchp_host_port.sv
/*
  Host parallel port of a battery-backed calendar clock: strobe decode,
  power-loss lockout, paged storage, interrupt flags, irq and multi-function pins.
  Assumes pins are asynchronous to clk; event inputs come from clk-domain logic.
*/
// What this block does
// R1 - read active while select and read low
// R2 - write active while select and store low
// R3 - lockout ignores strobes, running access finishes
// R4 - select lines pick location, ignored in lockout
// R5 - data floats when supply lost, no write
// R6 - lockout after 30 to 63 us; code adds lockout_extra_cycles unchecked, so up to about 718 us
// R7 - single supply: system ties supply-loss high
// R8 - irq on enabled timing or power event
// R9 - irq open-drain level, cleared writing one
// R10 - multi-function out: irq or oscillator
// R11 - push-pull normally, open-drain in standby
// R12 - periodic, alarm, power-fail masks and status
// R13 - oscillator runs with power and valid select
// R14 - two 31-byte pages plus common status
// R15 - page 0 clock functions, page 1 scratch
// R16 - block bit picks control register block
// R17 - controls in block 1, status block 0
// R18 - host enables source by writing one
// R19 - write captured at end of access
// R20 - data driven only during read access
`timescale 1ns/1ps
module rtchp_host_port
  import rtchp_pkg::*;
#(
  parameter int LOCK_CYCLES = rtchp_pkg::LOCK_MIN_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire rtchp_pkg::rtchp_pins_t  host_pins,
  input  wire rtchp_pkg::rtchp_power_t power_pins,
  input  wire logic [15:0]          lockout_extra_cycles,
  input  wire logic                 periodic_evt,
  input  wire logic                 alarm_evt,
  output logic [7:0]                host_data_lines_o,
  output logic                      host_data_lines_oe,
  output logic                      irq_out_n_o,
  output logic                      irq_out_n_oe,
  output logic                      multi_function_out_o,
  output logic                      multi_function_out_oe,
  output logic                      crystal_output,
  output logic                      osc_run,
  output logic                      host_lockout
);

  if (LOCK_CYCLES < LOCK_MIN_CYC || LOCK_CYCLES > LOCK_MAX_CYC) begin : g_bad_lock
    $error("LOCK_CYCLES outside the lockout window");
  end

  rtchp_pins_t  pins_s;
  rtchp_power_t pwr_s;

  rtchp_sync #(.WIDTH($bits(rtchp_pins_t)), .INIT({3'b111, 13'h0000})) u_pin_sync (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .din  (host_pins),
    .dout (pins_s)
  );

  rtchp_sync #(.WIDTH($bits(rtchp_power_t)), .INIT(3'b100)) u_pwr_sync (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .din  (power_pins),
    .dout (pwr_s)
  );

  wire       pf_low     = ~pwr_s.supply_loss_n;
  wire [4:0] sel        = pins_s.register_select_lines;
  // R1 read strobe qualify
  wire       rd_req     = ~pins_s.cs_n & ~pins_s.rd_n;
  // R2 write strobe qualify
  wire       wr_req     = ~pins_s.cs_n & ~pins_s.wr_n;

  logic        acc_rd;
  logic        acc_wr;
  logic [4:0]  wr_sel;
  logic [7:0]  wr_data;
  logic [16:0] lock_cnt;
  logic [7:0]  main_ctl;
  logic [3:1]  flags;
  logic [7:0]  ic0;
  logic [7:0]  ic1;
  logic [7:0]  rt_mode;
  logic [7:0]  store [2][PAGE_BYTES];

  // R3 new accesses refused in lockout, running one continues
  wire next_acc_rd = rd_req & (acc_rd | ~host_lockout);
  wire next_acc_wr = wr_req & (acc_wr | ~host_lockout);
  // R19 commit when the write access ends
  wire wr_commit   = acc_wr & ~next_acc_wr;

  wire [16:0] lock_limit = 17'(LOCK_CYCLES) + {1'b0, lockout_extra_cycles};

  wire page   = main_ctl[MS_PAGE];
  wire block  = main_ctl[MS_BLOCK];
  // R14 location zero is common to both pages
  wire at_main = (wr_sel == ADDR_MAIN);
  // R16 control overlay only on page 0, picked by block bit
  wire ctl_hit = ~page & block & (wr_sel >= ADDR_CTL_A) & (wr_sel <= ADDR_RT_MODE);
  wire [4:0] wr_idx = wr_sel - 5'h01;

  // R12 masks gate the three sources
  wire [3:1] enables = {ic0[IC0_ALARM], ic0[IC0_PERIODIC], ic1[IC1_SUPPLY_LOSS_N]};
  // R8 pending when an enabled source has fired
  wire irq_pend = |(flags & enables);

  wire [7:0] main_rd = {main_ctl[7:6], 2'b00, flags, irq_pend};
  wire [2:0] xsel    = rt_mode[RTM_XSEL_LO +: 3];
  wire [4:0] rd_idx  = sel - 5'h01;
  logic [7:0] rd_mux;

  // R4 select lines steer read location
  // R17 status in block 0, controls in block 1
  always_comb begin
    rd_mux = store[page][rd_idx];
    if (sel == ADDR_MAIN) begin
      rd_mux = main_rd;
    end else if (!page && !block && sel == ADDR_CTL_A) begin
      rd_mux = {6'h00, flags[MS_ALARM], flags[MS_PERIODIC]};
    end else if (!page && !block && sel == ADDR_CTL_B) begin
      rd_mux = {6'h00, host_lockout, flags[MS_SUPPLY_LOSS_N]};
    end else if (!page && block && sel == ADDR_CTL_A) begin
      rd_mux = ic0;
    end else if (!page && block && sel == ADDR_CTL_B) begin
      rd_mux = ic1;
    end else if (!page && block && sel == ADDR_RT_MODE) begin
      rd_mux = rt_mode;
    end
  end

  // access tracking and capture of the last address and data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_rd  <= 1'b0;
      acc_wr  <= 1'b0;
      wr_sel  <= 5'h00;
      wr_data <= 8'h00;
      host_data_lines_o <= 8'h00;
    end else if (ce) begin
      acc_rd <= next_acc_rd;
      acc_wr <= next_acc_wr;
      if (next_acc_wr) begin
        wr_sel  <= sel;
        wr_data <= pins_s.data;
      end
      host_data_lines_o <= rd_mux;
    end
  end

  // R6 lockout after the programmed supply-loss delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_cnt     <= 17'h00000;
      host_lockout <= 1'b0;
    end else if (ce) begin
      if (!pf_low) begin
        lock_cnt     <= 17'h00000;
        host_lockout <= 1'b0;
      end else if (!host_lockout) begin
        lock_cnt     <= lock_cnt + 17'h00001;
        host_lockout <= (lock_cnt == lock_limit - 17'h00001);
      end
    end
  end

  // R9 flags are sticky, written one clears, a new event wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= 3'b000;
    end else if (ce) begin
      flags[MS_SUPPLY_LOSS_N]    <= (pf_low & ~host_lockout & (lock_cnt == lock_limit - 17'h00001))
                          | (flags[MS_SUPPLY_LOSS_N] & ~(wr_commit & at_main & wr_data[MS_SUPPLY_LOSS_N]));
      flags[MS_PERIODIC] <= periodic_evt
                          | (flags[MS_PERIODIC] & ~(wr_commit & at_main & wr_data[MS_PERIODIC]));
      flags[MS_ALARM]    <= alarm_evt
                          | (flags[MS_ALARM] & ~(wr_commit & at_main & wr_data[MS_ALARM]));
    end
  end

  // R18 host enables sources through control block 1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      main_ctl <= CTL_RESET;
      ic0      <= CTL_RESET;
      ic1      <= CTL_RESET;
      rt_mode  <= CTL_RESET;
    end else if (ce && wr_commit) begin
      if (at_main) begin
        main_ctl <= wr_data & ~MS_W1C_MASK & 8'hC0;
      end else if (ctl_hit && wr_sel == ADDR_CTL_A) begin
        ic0 <= wr_data;
      end else if (ctl_hit && wr_sel == ADDR_CTL_B) begin
        ic1 <= wr_data;
      end else if (ctl_hit) begin
        rt_mode <= wr_data;
      end
    end
  end

  // R15 page 0 and scratch page 1 storage, no reset
  always_ff @(posedge clk) begin
    if (ce && wr_commit && !at_main && !ctl_hit) begin
      store[page][wr_idx] <= wr_data;
    end
  end

  // R13 oscillator gate
  assign osc_run = pwr_s.supply_loss_n & (xsel >= XSEL_FIRST) & (xsel <= XSEL_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crystal_output <= 1'b0;
    end else if (ce) begin
      crystal_output <= osc_run & ~pwr_s.crystal_input;
    end
  end

  // R5 R20 drive only in a read with supply present
  assign host_data_lines_oe = acc_rd & ~pf_low;

  // R9 open-drain: pulled low while pending
  assign irq_out_n_o  = 1'b0;
  assign irq_out_n_oe = irq_pend;

  // R10 multi-function source select
  wire mfo_val = rt_mode[RTM_MFO_OSC] ? crystal_output : irq_pend;
  // R11 push-pull, or open-drain in battery standby
  assign multi_function_out_o  = pwr_s.battery_standby ? 1'b0 : mfo_val;
  assign multi_function_out_oe = pwr_s.battery_standby ? ~mfo_val : 1'b1;

  sequence s_wr_end;
    acc_wr ##1 !acc_wr;
  endsequence

  sequence s_main_clear(int b);
    ce && wr_commit && at_main && wr_data[b];
  endsequence

  a_read_drive: assert property (@(posedge clk) disable iff (rst) // R20
    host_data_lines_oe |-> $past(rd_req) && !pf_low) else $error("data driven outside read");
  a_lock_delay: assert property (@(posedge clk) disable iff (rst) // R6
    $rose(host_lockout) |-> pf_low && lock_cnt == lock_limit) else $error("lockout early");
  a_lock_refuse: assert property (@(posedge clk) disable iff (rst) // R3
    ce && host_lockout && !acc_rd |=> !acc_rd) else $error("read started in lockout");
  a_pf_float: assert property (@(posedge clk) disable iff (rst) // R5
    pf_low |-> !host_data_lines_oe) else $error("data driven with supply lost");
  a_flag_wins: assert property (@(posedge clk) disable iff (rst) // R9
    s_main_clear(MS_PERIODIC) and periodic_evt |=> flags[MS_PERIODIC])
    else $error("event lost on clear");
  a_flag_clear: assert property (@(posedge clk) disable iff (rst) // R9
    s_main_clear(MS_ALARM) and !alarm_evt |=> !flags[MS_ALARM]) else $error("clear ignored");
  a_irq_raise: assert property (@(posedge clk) disable iff (rst) // R8
    ce && periodic_evt && ic0[IC0_PERIODIC] && !wr_commit |=> irq_out_n_oe)
    else $error("irq not raised");
  a_write_end: assert property (@(posedge clk) disable iff (rst) // R19
    s_wr_end |-> $past(wr_commit)) else $error("commit missing");
  a_mfo_drain: assert property (@(posedge clk) disable iff (rst) // R11
    pwr_s.battery_standby |-> !(multi_function_out_oe && multi_function_out_o))
    else $error("mfo drives high in standby");
  a_osc_gate: assert property (@(posedge clk) disable iff (rst) // R13
    ce && !osc_run |=> !crystal_output) else $error("oscillator out while stopped");

endmodule : rtchp_host_port

// ===== src/rtchp_sync.sv
/*
  Two-stage synchroniser for a bundle of pin levels.
  Assumes the first stage is read by the second stage only.
*/
`timescale 1ns/1ps
module rtchp_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= INIT;
      dout   <= INIT;
    end else if (ce) begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule : rtchp_sync

// ===== testbench/rtchp_host_model.sv
/*
  Host processor model for the calendar clock parallel port.
  Assumes the device clock paces the host and the data pins resolve here.
*/
`timescale 1ns/1ps
module rtchp_host_model (
  input  wire logic                  clk,
  input  wire logic                  data_oe,
  input  wire logic [7:0]            data_o,
  output wire rtchp_pkg::rtchp_pins_t pins
);
  import rtchp_pkg::*;
  logic       cs_n = 1'b1;
  logic       rd_n = 1'b1;
  logic       wr_n = 1'b1;
  logic [4:0] sel  = 5'h00;
  logic [7:0] drv  = 8'h00;

  // released bus shows the inverse of the last byte
  assign pins = {cs_n, rd_n, wr_n, sel, (data_oe ? data_o : drv)};

  task automatic access(input logic w, input logic [4:0] s, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk);
    sel  <= s;
    drv  <= d;
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= ~w;
    repeat (6) @(posedge clk);
    #1 q = pins.data;
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (3) @(posedge clk);
    drv <= ~d;
    #1;
  endtask : access
endmodule : rtchp_host_model

// ===== testbench/tb.sv
/*
  Self-checking bench for the calendar clock host port.
  Assumes the host model drives the pins; events come from this bench.
*/
`timescale 1ns/1ps
module tb;
  import rtchp_pkg::*;
  typedef struct packed {
    logic [7:0] main;
    logic [4:0] sel;
    logic [7:0] d;
  } rtchp_row_t;
  rtchp_row_t   rows [4] = '{'{8'h00, 5'h05, 8'hA5}, '{8'h80, 5'h05, 8'h5A},
                             '{8'h80, 5'h1F, 8'hFF}, '{8'h00, 5'h1F, 8'h00}};
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         per = 1'b0;
  logic         alm = 1'b0;
  rtchp_power_t pwr = 3'b100;
  rtchp_pins_t  pins;
  logic [7:0]   d_o;
  logic [7:0]   q;
  logic         d_oe, irq_o, irq_oe, mfo_o, mfo_oe, xo, osc, lock;
  int           fails = 0;
  int           samples_checked = 0;
  int           n;
  int           oe_seen = 0;

  initial forever #5 clk = ~clk;
  always @(posedge clk) if (d_oe === 1'b1) oe_seen <= oe_seen + 1;

  rtchp_host_port rtchp_host_port_inst (.clk(clk), .rst(rst), .ce(1'b1), .host_pins(pins),
    .power_pins(pwr), .lockout_extra_cycles(16'h0000), .periodic_evt(per), .alarm_evt(alm),
    .host_data_lines_o(d_o), .host_data_lines_oe(d_oe), .irq_out_n_o(irq_o),
    .irq_out_n_oe(irq_oe), .multi_function_out_o(mfo_o), .multi_function_out_oe(mfo_oe),
    .crystal_output(xo), .osc_run(osc), .host_lockout(lock));
  rtchp_host_model rtchp_host_model_inst (.clk(clk), .data_oe(d_oe), .data_o(d_o),
    .pins(pins));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [4:0] s, input logic [7:0] d);
    rtchp_host_model_inst.access(1'b1, s, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] s);
    rtchp_host_model_inst.access(1'b0, s, 8'h00, q);
  endtask : rd
  task automatic pulse(input logic a);
    @(posedge clk);
    if (a) alm <= 1'b1;
    else per <= 1'b1;
    @(posedge clk);
    alm <= 1'b0;
    per <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse
  task automatic finish_test();
    $display("samples_checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    #100_000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("idle_oe", 8'h00, {7'h00, d_oe});
    chk("mfo_oe", 8'h01, {7'h00, mfo_oe});
    foreach (rows[i]) begin
      wr(ADDR_MAIN, rows[i].main);
      wr(rows[i].sel, rows[i].d);
    end
    foreach (rows[i]) begin
      wr(ADDR_MAIN, rows[i].main);
      rd(rows[i].sel);
      chk("row", rows[i].d, q);
    end
    wr(ADDR_MAIN, 8'h40);
    wr(ADDR_CTL_A, 8'h01);
    wr(ADDR_RT_MODE, 8'h02);
    chk("osc_on", 8'h01, {7'h00, osc});
    pulse(1'b1);
    chk("irq_masked", 8'h00, {7'h00, irq_oe});
    pulse(1'b0);
    chk("irq_set", 8'h02, {6'h00, irq_oe, irq_o});
    chk("mfo_irq", 8'h01, {7'h00, mfo_o});
    rd(ADDR_MAIN);
    chk("status", 8'h45, q & 8'h45);
    fork
      wr(ADDR_MAIN, 8'h44);
      begin
        repeat (10) @(posedge clk);
        per <= 1'b1;
        @(posedge clk);
        per <= 1'b0;
      end
    join
    chk("set_wins", 8'h01, {7'h00, irq_oe});
    wr(ADDR_MAIN, 8'h4E);
    chk("irq_clr", 8'h00, {7'h00, irq_oe});
    wr(ADDR_RT_MODE, 8'h0A);
    chk("mfo_osc", 8'h01, {7'h00, mfo_o});
    chk("xo_run", 8'h01, {7'h00, xo});
    @(posedge clk);
    pwr.battery_standby <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("mfo_od", 8'h00, {6'h00, mfo_o, mfo_oe});
    pwr.battery_standby <= 1'b0;
    wr(ADDR_RT_MODE, 8'h00);
    chk("osc_off", 8'h00, {7'h00, osc});
    @(posedge clk);
    pwr.supply_loss_n <= 1'b0;
    oe_seen = 0;
    n = 0;
    rd(5'h05);
    chk("float", 8'h00, oe_seen[7:0]);
    while (lock !== 1'b1 && n < 7000) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = n + 11;
    chk("lock_min", 8'h01, {7'h00, n >= LOCK_MIN_CYC});
    chk("lock_max", 8'h01, {7'h00, n <= LOCK_MAX_CYC});
    wr(5'h05, 8'h3C);
    rd(5'h05);
    chk("locked_oe", 8'h00, oe_seen[7:0]);
    @(posedge clk);
    pwr.supply_loss_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("unlock", 8'h00, {7'h00, lock});
    rd(ADDR_MAIN);
    chk("supply_loss_n_flag", 8'h02, q & 8'h02);
    rd(5'h05);
    chk("kept", 8'hA5, q);
    finish_test();
  end
endmodule : tb
